// File: mrl_pkg.sv
package mrl_pkg;
// Contract
// - a frame ends after 3.5 character times of silence; only then is it processed
// - hold unit address 1 to 99; answer only frames carrying that address
// - frame is address, function, data bytes, 16-bit CRC, framed by silence
// - serve functions 03, 04, 06 and 08 loop-back
// - function 04 query start and count high first; reply byte count then words
// - function 03 query start and count high first; reply byte count then words
// - function 06 reply echoes register address and data high first plus CRC
// - input register 0 is distance, register 2 is level, in millimetres
// - input register 4 level percent, 17 flow percent, full scale 10000
// - total flow 32 bits: upper half register 18, lower half register 19
// - writing 1 to holding register 39 clears the total flow
// - characters are start, eight data, parity none/odd/even, one stop bit
// - reply starts within ten character times after a valid query
// - unit address is zero after reset and must be set before use

    // clock and character timing
    localparam longint CLK_HZ = 200_000_000;
    localparam longint BAUD_DEFAULT = 9600;
    localparam longint BITS_PER_CHAR = 11; // start, eight data, parity, stop
    localparam longint CHAR_CYCLES = (CLK_HZ * BITS_PER_CHAR + BAUD_DEFAULT - 1) / BAUD_DEFAULT;
    localparam real GAP_CHARS = 3.5;
    localparam longint GAP_TENTHS = longint'(GAP_CHARS * 10.0);
    localparam int GAP_CYCLES_DEFAULT = int'((CHAR_CYCLES * GAP_TENTHS + 9) / 10);
    localparam int GAP_W = 24;
    typedef logic [GAP_W-1:0] mrl_gap_t;

    // function and exception codes
    localparam logic [7:0] FN_RD_HOLD = 8'h03;
    localparam logic [7:0] FN_RD_INPUT = 8'h04;
    localparam logic [7:0] FN_WR_SINGLE = 8'h06;
    localparam logic [7:0] FN_LOOPBACK = 8'h08;
    localparam logic [7:0] FN_EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;

    // unit address
    localparam logic [7:0] UNIT_ADDR_RST = 8'h00;
    localparam logic [7:0] UNIT_ADDR_MIN = 8'h01;
    localparam logic [7:0] UNIT_ADDR_MAX = 8'h63;

    // frame layout and sizes
    localparam int FRM_ADDR = 0;
    localparam int FRM_FUNC = 1;
    localparam int FRM_REG_HI = 2;
    localparam int FRM_REG_LO = 3;
    localparam int FRM_VAL_HI = 4;
    localparam int FRM_VAL_LO = 5;
    localparam logic [7:0] FRAME_BYTES = 8'h08;
    localparam logic [7:0] RSP_OVERHEAD = 8'h05; // address, function, count, two crc
    localparam logic [7:0] EXC_LEN = 8'h05;
    localparam logic [15:0] MAX_WORDS = 16'h007D;
    localparam logic [16:0] INPUT_WORDS = 17'h00014;
    localparam logic [16:0] HOLD_WORDS = 17'h00028;
    localparam int HOLD_DEPTH = 40;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] VOLUME_CLEAR_CMD = 16'h0001;

    // input register offsets
    localparam logic [5:0] IR_DISTANCE = 6'h00, IR_LEVEL = 6'h02, IR_LEVEL_PCT = 6'h04, IR_NOISE = 6'h06;
    localparam logic [5:0] IR_ECHO = 6'h08, IR_PROBE_TEMP = 6'h0A, IR_HOUSING_TEMP = 6'h0C, IR_PEAK_FLOW = 6'h0D;
    localparam logic [5:0] IR_FLOW_RATE = 6'h0E, IR_VOLUME = 6'h0F, IR_OVERFLOW = 6'h10, IR_FLOW_PCT = 6'h11;
    localparam logic [5:0] IR_VOLUME_HI = 6'h12, IR_VOLUME_LO = 6'h13;

    // holding register offsets
    localparam logic [5:0] HR_TRACK = 6'h00, HR_THRESH = 6'h01, HR_GAIN_TIME = 6'h02, HR_HOLD_AVERAGING_COUNT = 6'h03;
    localparam logic [5:0] HR_FLOOR = 6'h04, HR_FULL_SCALE = 6'h05, HR_HI_ON = 6'h06, HR_HI_OFF = 6'h07;
    localparam logic [5:0] HR_LO_ON = 6'h0C, HR_LO_OFF = 6'h0D, HR_LOOP_ZERO = 6'h0E, HR_CHAN_WIDTH = 6'h1C;
    localparam logic [5:0] HR_NOTCH_WIDTH = 6'h1D, HR_CREST = 6'h1E, HR_NOTCH_ANGLE = 6'h1F, HR_FLOW_METHOD = 6'h20;
    localparam logic [5:0] HR_CUTOFF = 6'h24, HR_FLOW_FLOOR = 6'h25, HR_FLOW_SCALE = 6'h26, HR_VOLUME_CLEAR = 6'h27;

    typedef enum logic [2:0] {S_RX, S_EVAL, S_FETCH, S_LOAD, S_SEND} mrl_state_t;
    typedef enum logic [1:0] {K_READ, K_ECHO, K_EXC} mrl_kind_t;
    typedef struct packed {
        logic ok;
        logic store;
        logic [15:0] lo;
        logic [15:0] hi;
    } mrl_range_t;

    // reflected crc, one byte at a time
    function automatic logic [15:0] mrl_crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

    // write window of each listed holding register; any other offset is refused
    function automatic mrl_range_t mrl_hold_range(input logic [5:0] a);
        mrl_range_t r;
        r = '{ok: 1'b1, store: 1'b1, lo: 16'h0000, hi: 16'h07D0};
        case (a)
            HR_TRACK: r.hi = 16'h0005;
            HR_THRESH: r.hi = 16'h0008;
            HR_GAIN_TIME: r.hi = 16'h000A;
            HR_HOLD_AVERAGING_COUNT: r = '{ok: 1'b1, store: 1'b1, lo: 16'h0001, hi: 16'h001E};
            HR_FLOOR: r = '{ok: 1'b1, store: 1'b1, lo: 16'h001E, hi: 16'h07EE};
            HR_FULL_SCALE, HR_HI_ON, HR_HI_OFF, HR_LO_ON, HR_LO_OFF, HR_LOOP_ZERO: r.hi = 16'h07D0;
            HR_CHAN_WIDTH: r = '{ok: 1'b1, store: 1'b1, lo: 16'h0190, hi: 16'h1B58};
            HR_NOTCH_WIDTH: r = '{ok: 1'b1, store: 1'b1, lo: 16'h0096, hi: 16'h1388};
            HR_CREST: r = '{ok: 1'b1, store: 1'b1, lo: 16'h0001, hi: 16'h0DAC};
            HR_NOTCH_ANGLE: r = '{ok: 1'b1, store: 1'b1, lo: 16'h01C2, hi: 16'h03E8};
            HR_FLOW_METHOD: r.hi = 16'h0016;
            HR_CUTOFF: r.hi = 16'h0064;
            HR_FLOW_FLOOR: r = '{ok: 1'b1, store: 1'b1, lo: 16'h012C, hi: 16'h1388};
            HR_FLOW_SCALE: r = '{ok: 1'b1, store: 1'b1, lo: 16'h0032, hi: 16'h0BB8};
            HR_VOLUME_CLEAR: r = '{ok: 1'b1, store: 1'b0, lo: 16'h0000, hi: 16'h0001};
            default: r.ok = 1'b0;
        endcase
        return r;
    endfunction
endpackage

// File: mrl_hreg_if.sv
`timescale 1ns/100ps
interface mrl_hreg_if;
    logic we;
    logic [5:0] waddr;
    logic [15:0] wdata;
    logic [5:0] raddr;
    logic [15:0] rdata;
    logic [5:0] cfg_raddr;
    logic [15:0] cfg_rdata;
    modport ctrl(output we, output waddr, output wdata, output raddr, output cfg_raddr,
                 input rdata, input cfg_rdata);
    modport mem(input we, input waddr, input wdata, input raddr, input cfg_raddr,
                output rdata, output cfg_rdata);
endinterface

// File: mrl_hreg_mem.sv
`timescale 1ns/100ps
module mrl_hreg_mem (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // access from the frame engine and the configuration reader
    mrl_hreg_if.mem hw
);
    logic [15:0] mem_ff [0:mrl_pkg::HOLD_DEPTH-1];

    // read data registered; a same-cycle write returns the old word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < mrl_pkg::HOLD_DEPTH; i++) begin
                mem_ff[i] <= 16'h0000;
            end
            hw.rdata <= 16'h0000;
            hw.cfg_rdata <= 16'h0000;
        end else begin
            if (hw.we && ({11'h000, hw.waddr} < mrl_pkg::HOLD_WORDS)) begin
                mem_ff[hw.waddr] <= hw.wdata;
            end
            hw.rdata <= ({11'h000, hw.raddr} < mrl_pkg::HOLD_WORDS) ? mem_ff[hw.raddr] : 16'h0000;
            hw.cfg_rdata <= ({11'h000, hw.cfg_raddr} < mrl_pkg::HOLD_WORDS) ? mem_ff[hw.cfg_raddr] : 16'h0000;
        end
    end
endmodule

// File: mrl_slave.sv
`timescale 1ns/100ps
module mrl_slave #(
    parameter int GAP_CYCLES = mrl_pkg::GAP_CYCLES_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bytes from the character receiver
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_error,
    // bytes to the character transmitter
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic resp_active,
    // unit address setting
    input wire logic addr_set_valid,
    input wire logic [7:0] addr_set_value,
    output logic [7:0] unit_addr,
    // measurements
    input wire logic [15:0] meas_distance,
    input wire logic [15:0] meas_level,
    input wire logic [15:0] meas_level_pct,
    input wire logic [15:0] meas_noise,
    input wire logic [15:0] meas_echo,
    input wire logic [15:0] meas_probe_temp,
    input wire logic [15:0] meas_housing_temp,
    input wire logic [15:0] meas_peak_flow,
    input wire logic [15:0] meas_flow_rate,
    input wire logic [15:0] meas_overflow,
    input wire logic [15:0] meas_flow_pct,
    // total flow accumulator
    input wire logic vol_add_valid,
    input wire logic [15:0] vol_add,
    output logic [31:0] vol_total,
    // configuration read port
    input wire logic [5:0] cfg_addr,
    output logic [15:0] cfg_data
);
    typedef struct packed {
        mrl_pkg::mrl_state_t st;
        mrl_pkg::mrl_kind_t kind;
        logic [7:0][7:0] frm;
        logic [7:0] cnt;
        logic bad;
        logic quiet;
        mrl_pkg::mrl_gap_t gap;
        logic [15:0] crc;
        logic [7:0] idx;
        logic [7:0] len;
        logic [7:0] exc;
        logic [5:0] start;
        logic [6:0] nwords;
        logic [15:0] word;
        logic [7:0] txb;
        logic [7:0] uaddr;
        logic [31:0] vol;
    } mrl_core_t;

    localparam mrl_pkg::mrl_gap_t GAP_LAST = mrl_pkg::mrl_gap_t'(GAP_CYCLES - 1);

    mrl_core_t r;
    mrl_core_t n;
    logic [7:0] fn;
    logic [15:0] a16;
    logic [15:0] v16;
    logic [16:0] end17;
    mrl_pkg::mrl_range_t rng;
    logic gap_hit;
    logic frame_ok;
    logic hw_we;
    logic vol_clear;
    logic [15:0] word_now;
    logic [6:0] widx;

    mrl_hreg_if hw();

    mrl_hreg_mem u_mem (
        .clk(clk),
        .rst(rst),
        .hw(hw)
    );

    // input register map; gaps read as zero
    function automatic logic [15:0] in_word(input logic [5:0] a);
        case (a)
            mrl_pkg::IR_DISTANCE: return meas_distance;
            mrl_pkg::IR_LEVEL: return meas_level;
            mrl_pkg::IR_LEVEL_PCT: return meas_level_pct;
            mrl_pkg::IR_NOISE: return meas_noise;
            mrl_pkg::IR_ECHO: return meas_echo;
            mrl_pkg::IR_PROBE_TEMP: return meas_probe_temp;
            mrl_pkg::IR_HOUSING_TEMP: return meas_housing_temp;
            mrl_pkg::IR_PEAK_FLOW: return meas_peak_flow;
            mrl_pkg::IR_FLOW_RATE: return meas_flow_rate;
            mrl_pkg::IR_VOLUME: return r.vol[15:0];
            mrl_pkg::IR_OVERFLOW: return meas_overflow;
            mrl_pkg::IR_FLOW_PCT: return meas_flow_pct;
            mrl_pkg::IR_VOLUME_HI: return r.vol[31:16];
            mrl_pkg::IR_VOLUME_LO: return r.vol[15:0];
            default: return 16'h0000;
        endcase
    endfunction

    // high byte of a data word in a read reply
    function automatic logic data_hi(input mrl_pkg::mrl_kind_t k, input logic [7:0] i, input logic [7:0] l);
        return (k == mrl_pkg::K_READ) && (i >= 8'h03) && (i < l - 8'h02) && i[0];
    endfunction

    // word number of a reply byte position
    function automatic logic [6:0] word_index(input logic [7:0] i);
        logic [7:0] rel;
        rel = i - 8'h03;
        return rel[7:1];
    endfunction

    // memory ports; raddr is held through fetch and load
    assign hw.we = hw_we;
    assign hw.waddr = a16[5:0];
    assign hw.wdata = v16;
    assign hw.raddr = r.start + widx[5:0];
    assign hw.cfg_raddr = cfg_addr;

    // outputs
    assign tx_valid = (r.st == mrl_pkg::S_SEND);
    assign tx_data = r.txb;
    assign resp_active = (r.st == mrl_pkg::S_FETCH) || (r.st == mrl_pkg::S_LOAD) || (r.st == mrl_pkg::S_SEND);
    assign unit_addr = r.uaddr;
    assign vol_total = r.vol;
    assign cfg_data = hw.cfg_rdata;

    // next-state logic for the whole engine
    always_comb begin
        n = r;
        fn = r.frm[mrl_pkg::FRM_FUNC];
        a16 = {r.frm[mrl_pkg::FRM_REG_HI], r.frm[mrl_pkg::FRM_REG_LO]};
        v16 = {r.frm[mrl_pkg::FRM_VAL_HI], r.frm[mrl_pkg::FRM_VAL_LO]};
        end17 = {1'b0, a16} + {1'b0, v16};
        rng = mrl_pkg::mrl_hold_range(a16[5:0]);
        gap_hit = (r.gap >= GAP_LAST);
        // a zero address never matches, so a fresh unit stays off the bus
        frame_ok = !r.bad && (r.crc == 16'h0000) && (r.cnt >= 8'h04)
            && (r.frm[mrl_pkg::FRM_ADDR] == r.uaddr) && (r.uaddr != mrl_pkg::UNIT_ADDR_RST);
        hw_we = 1'b0;
        vol_clear = 1'b0;
        widx = word_index(r.idx);
        word_now = r.word;
        // out-of-range settings are ignored
        if (addr_set_valid && (addr_set_value >= mrl_pkg::UNIT_ADDR_MIN)
            && (addr_set_value <= mrl_pkg::UNIT_ADDR_MAX)) begin
            n.uaddr = addr_set_value;
        end
        case (r.st)
            mrl_pkg::S_RX: begin
                if (rx_valid) begin
                    n.gap = '0;
                    // a frame must be preceded by silence; char errors spoil it
                    if (((r.cnt == 8'h00) && !r.quiet) || rx_error) begin
                        n.bad = 1'b1;
                    end
                    if (r.cnt < mrl_pkg::FRAME_BYTES) begin
                        n.frm[r.cnt[2:0]] = rx_data;
                    end
                    if (r.cnt != 8'hFF) begin
                        n.cnt = r.cnt + 8'h01;
                    end
                    // crc runs over every byte, stored or not
                    n.crc = mrl_pkg::mrl_crc_byte((r.cnt == 8'h00) ? mrl_pkg::CRC_INIT : r.crc, rx_data);
                end else if (gap_hit) begin
                    n.quiet = 1'b1;
                    if (r.cnt != 8'h00) begin
                        n.st = mrl_pkg::S_EVAL;
                    end
                end else begin
                    n.gap = r.gap + mrl_pkg::mrl_gap_t'(1);
                end
            end

            mrl_pkg::S_EVAL: begin
                // rearm the receiver whatever the verdict
                n.cnt = 8'h00;
                n.bad = 1'b0;
                n.idx = 8'h00;
                n.crc = mrl_pkg::CRC_INIT;
                n.st = mrl_pkg::S_RX;
                if (frame_ok) begin
                    n.st = mrl_pkg::S_LOAD;
                    n.kind = mrl_pkg::K_EXC;
                    n.len = mrl_pkg::EXC_LEN;
                    n.exc = mrl_pkg::EXC_FUNC;
                    case (fn)
                        mrl_pkg::FN_RD_HOLD, mrl_pkg::FN_RD_INPUT: begin
                            if ((r.cnt != mrl_pkg::FRAME_BYTES) || (v16 == 16'h0000) || (v16 > mrl_pkg::MAX_WORDS)) begin
                                n.exc = mrl_pkg::EXC_VALUE;
                            end else if (end17 > ((fn == mrl_pkg::FN_RD_HOLD) ? mrl_pkg::HOLD_WORDS
                                                                             : mrl_pkg::INPUT_WORDS)) begin
                                n.exc = mrl_pkg::EXC_ADDR;
                            end else begin
                                n.kind = mrl_pkg::K_READ;
                                n.start = a16[5:0];
                                n.nwords = v16[6:0];
                                n.len = mrl_pkg::RSP_OVERHEAD + {v16[6:0], 1'b0};
                            end
                        end

                        mrl_pkg::FN_WR_SINGLE: begin
                            if (r.cnt != mrl_pkg::FRAME_BYTES) begin
                                n.exc = mrl_pkg::EXC_VALUE;
                            end else if (!rng.ok || (a16[15:6] != 10'h000)) begin
                                n.exc = mrl_pkg::EXC_ADDR;
                            end else if ((v16 < rng.lo) || (v16 > rng.hi)) begin
                                n.exc = mrl_pkg::EXC_VALUE;
                            end else begin
                                n.kind = mrl_pkg::K_ECHO;
                                n.len = mrl_pkg::FRAME_BYTES;
                                hw_we = rng.store;
                                if ((a16[5:0] == mrl_pkg::HR_VOLUME_CLEAR) && (v16 == mrl_pkg::VOLUME_CLEAR_CMD)) begin
                                    vol_clear = 1'b1;
                                end
                            end
                        end

                        mrl_pkg::FN_LOOPBACK: begin
                            if (r.cnt != mrl_pkg::FRAME_BYTES) begin
                                n.exc = mrl_pkg::EXC_VALUE;
                            end else begin
                                n.kind = mrl_pkg::K_ECHO;
                                n.len = mrl_pkg::FRAME_BYTES;
                            end
                        end

                        default: n.exc = mrl_pkg::EXC_FUNC;
                    endcase
                end
            end

            mrl_pkg::S_FETCH: begin
                // memory read data is registered, so give it one cycle
                n.st = mrl_pkg::S_LOAD;
            end

            mrl_pkg::S_LOAD: begin
                // one register read per word; the low byte reuses the latched word
                if (data_hi(r.kind, r.idx, r.len)) begin
                    word_now = (fn == mrl_pkg::FN_RD_HOLD) ? hw.rdata : in_word(r.start + widx[5:0]);
                end
                n.word = word_now;
                if (r.kind == mrl_pkg::K_ECHO) begin
                    n.txb = r.frm[r.idx[2:0]];
                end else if (r.idx == r.len - 8'h02) begin
                    n.txb = r.crc[7:0];
                end else if (r.idx == r.len - 8'h01) begin
                    n.txb = r.crc[15:8];
                end else if (r.idx == 8'h00) begin
                    n.txb = r.uaddr;
                end else if (r.idx == 8'h01) begin
                    n.txb = (r.kind == mrl_pkg::K_EXC) ? (fn | mrl_pkg::FN_EXC_FLAG) : fn;
                end else if (r.idx == 8'h02) begin
                    n.txb = (r.kind == mrl_pkg::K_EXC) ? r.exc : {r.nwords, 1'b0};
                end else begin
                    n.txb = r.idx[0] ? word_now[15:8] : r.word[7:0];
                end
                n.st = mrl_pkg::S_SEND;
            end

            mrl_pkg::S_SEND: begin
                if (tx_ready) begin
                    // the two crc bytes stay out of the running crc
                    if (r.idx < r.len - 8'h02) begin
                        n.crc = mrl_pkg::mrl_crc_byte(r.crc, r.txb);
                    end
                    n.idx = r.idx + 8'h01;
                    if (r.idx + 8'h01 == r.len) begin
                        // own reply counts as traffic; wait for fresh silence
                        n.st = mrl_pkg::S_RX;
                        n.gap = '0;
                        n.quiet = 1'b0;
                    end else if (data_hi(r.kind, r.idx + 8'h01, r.len)) begin
                        n.st = mrl_pkg::S_FETCH;
                    end else begin
                        n.st = mrl_pkg::S_LOAD;
                    end
                end
            end

            default: n.st = mrl_pkg::S_RX;
        endcase

        // clear wins over an increment in the same cycle; the total wraps at 32 bits
        if (vol_clear) begin
            n.vol = 32'h00000000;
        end else if (vol_add_valid) begin
            n.vol = r.vol + {16'h0000, vol_add};
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '{st: mrl_pkg::S_RX, kind: mrl_pkg::K_EXC, uaddr: mrl_pkg::UNIT_ADDR_RST,
                   crc: mrl_pkg::CRC_INIT, default: '0};
        end else begin
            r <= n;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    gap_before_eval_a: assert property (r.st == mrl_pkg::S_EVAL |-> $past(r.st) == mrl_pkg::S_RX
        && $past(r.gap) == GAP_LAST && !$past(rx_valid)) else $error("frame evaluated before full silence");

    reply_addr_a: assert property (tx_valid && r.idx == 8'h00 |-> tx_data == r.uaddr
        && r.uaddr != 8'h00) else $error("reply sent for a foreign address");

    unit_addr_range_a: assert property (r.uaddr <= mrl_pkg::UNIT_ADDR_MAX
        && (r.uaddr == 8'h00 || $past(r.uaddr) != 8'h00 || $past(addr_set_valid)))
        else $error("unit address out of range");

    crc_drop_a: assert property (r.st == mrl_pkg::S_EVAL && r.crc != 16'h0000
        |=> r.st == mrl_pkg::S_RX && !tx_valid ##1 !tx_valid) else $error("bad crc frame answered");

    char_error_drop_a: assert property (r.st == mrl_pkg::S_EVAL && r.bad
        |=> r.st == mrl_pkg::S_RX && !tx_valid) else $error("spoiled frame answered");

    reply_start_a: assert property (r.st == mrl_pkg::S_EVAL && frame_ok
        |-> ##2 tx_valid && r.idx == 8'h00) else $error("reply start late");

    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped before taken");

    byte_count_a: assert property (tx_valid && r.kind == mrl_pkg::K_READ && r.idx == 8'h02
        |-> tx_data == {r.nwords, 1'b0} && r.len == tx_data + 8'h05) else $error("wrong byte count");

    volume_clear_a: assert property (vol_clear |=> vol_total == 32'h00000000)
        else $error("total flow not cleared");

    range_refuse_a: assert property (r.st == mrl_pkg::S_EVAL && frame_ok && fn == mrl_pkg::FN_WR_SINGLE
        && r.cnt == 8'h08 && rng.ok && a16[15:6] == 10'h000 && v16 > rng.hi
        |-> !hw_we ##1 r.kind == mrl_pkg::K_EXC && r.exc == mrl_pkg::EXC_VALUE) else $error("range write taken");

    volume_split_a: assert property (r.st == mrl_pkg::S_LOAD && fn == mrl_pkg::FN_RD_INPUT
        && data_hi(r.kind, r.idx, r.len) && (r.start + widx[5:0]) == mrl_pkg::IR_VOLUME_HI
        |=> r.word == $past(r.vol[31:16])) else $error("total flow high half wrong");
endmodule

// File: mrl_host.sv
`timescale 1ns/100ps
module mrl_host (
    // clock
    input wire logic clk,
    // bytes into the slave
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_error,
    // bytes out of the slave
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    logic [7:0] got[$];
    // slow master: ready only every other cycle, so the slave must hold its byte
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_error = 1'b0;
        tx_ready = 1'b0;
        forever begin
            @(posedge clk);
            if (tx_valid && tx_ready) got.push_back(tx_data);
            #1 tx_ready = ~tx_ready;
        end
    end
    // reflected crc over a byte list
    function automatic logic [15:0] crc(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        return c;
    endfunction
    // one byte every third cycle, far inside the silence limit
    task automatic send(input logic [7:0] b[$], input logic bad);
        logic [15:0] c;
        c = crc(b) ^ {15'h0000, bad};
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        foreach (b[i]) begin
            @(posedge clk);
            #1 rx_valid = 1'b1;
            rx_data = b[i];
            @(posedge clk);
            #1 rx_valid = 1'b0;
            rx_data = ~b[i];
            @(posedge clk);
        end
    endtask
endmodule

// File: testbench.sv
`timescale 1ns/100ps
module testbench;
    `define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin num_errors++; $display("unexpected %s exp %h got %h", n, e, a); end end
    logic clk, rst, rx_valid, rx_error, tx_valid, tx_ready, resp_active, addr_set_valid, vol_add_valid;
    logic [7:0] rx_data, tx_data, addr_set_value, unit_addr;
    logic [15:0] vol_add, cfg_data;
    logic [15:0] meas [11];
    logic [31:0] vol_total;
    logic [5:0] cfg_addr;
    int num_errors, total_checks;
    mrl_host host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_error(rx_error),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    // short gap keeps the run brief
    mrl_slave #(.GAP_CYCLES(20)) uut (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_error(rx_error), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .resp_active(resp_active), .addr_set_valid(addr_set_valid), .addr_set_value(addr_set_value),
        .unit_addr(unit_addr), .meas_distance(meas[0]), .meas_level(meas[1]), .meas_level_pct(meas[2]),
        .meas_noise(meas[3]), .meas_echo(meas[4]), .meas_probe_temp(meas[5]), .meas_housing_temp(meas[6]),
        .meas_peak_flow(meas[7]), .meas_flow_rate(meas[8]), .meas_overflow(meas[9]), .meas_flow_pct(meas[10]),
        .vol_add_valid(vol_add_valid), .vol_add(vol_add), .vol_total(vol_total), .cfg_addr(cfg_addr),
        .cfg_data(cfg_data));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task summarize();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task set_addr(input logic [7:0] v);
        @(posedge clk);
        #1 addr_set_value = v;
        addr_set_valid = 1'b1;
        @(posedge clk);
        #1 addr_set_valid = 1'b0;
    endtask
    // send a query, then compare the whole reply including its crc
    task xact(input logic [7:0] q[$], input logic bad, input logic [7:0] e[$]);
        logic [15:0] c;
        c = host.crc(e);
        if (e.size() > 0) e = {e, c[7:0], c[15:8]};
        host.got.delete();
        host.send(q, bad);
        repeat (30) @(posedge clk);
        for (int i = 0; i < 600 && (resp_active || host.got.size() < e.size()); i++) @(posedge clk);
        `CHK("reply_done", 1'b0, resp_active)
        `CHK("reply_len", e.size(), host.got.size())
        foreach (e[i]) `CHK("reply_byte", e[i], host.got[i])
        repeat (25) @(posedge clk);
    endtask
    task t_addr();
        `CHK("addr_reset", 8'h00, unit_addr)
        set_addr(8'h64);
        `CHK("addr_100", 8'h00, unit_addr)
        set_addr(8'h05);
        `CHK("addr_5", 8'h05, unit_addr)
        repeat (25) @(posedge clk);
    endtask
    task t_read();
        xact('{8'h05, 8'h04, 8'h00, 8'h00, 8'h00, 8'h05}, 1'b0, '{8'h05, 8'h04, 8'h0A, 8'h01, 8'h00, 8'h00,
            8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h01, 8'h02});
        #1 vol_add = 16'hFFFF;
        vol_add_valid = 1'b1;
        @(posedge clk);
        #1 vol_add = 16'h0003;
        @(posedge clk);
        #1 vol_add_valid = 1'b0;
        xact('{8'h05, 8'h04, 8'h00, 8'h11, 8'h00, 8'h03}, 1'b0,
            '{8'h05, 8'h04, 8'h06, 8'h01, 8'h0A, 8'h00, 8'h01, 8'h00, 8'h02});
        xact('{8'h05, 8'h04, 8'h00, 8'h12, 8'h00, 8'h03}, 1'b0, '{8'h05, 8'h84, 8'h02});
    endtask
    task t_write();
        xact('{8'h05, 8'h06, 8'h00, 8'h27, 8'h00, 8'h01}, 1'b0, '{8'h05, 8'h06, 8'h00, 8'h27, 8'h00, 8'h01});
        `CHK("vol_cleared", 32'h00000000, vol_total)
        xact('{8'h05, 8'h06, 8'h00, 8'h03, 8'h00, 8'h1F}, 1'b0, '{8'h05, 8'h86, 8'h03});
        `CHK("cfg_kept", 16'h0000, cfg_data)
        xact('{8'h05, 8'h06, 8'h00, 8'h03, 8'h00, 8'h1E}, 1'b0, '{8'h05, 8'h06, 8'h00, 8'h03, 8'h00, 8'h1E});
        `CHK("cfg_new", 16'h001E, cfg_data)
        xact('{8'h05, 8'h03, 8'h00, 8'h03, 8'h00, 8'h01}, 1'b0, '{8'h05, 8'h03, 8'h02, 8'h00, 8'h1E});
        xact('{8'h05, 8'h08, 8'h00, 8'h00, 8'hAB, 8'hCD}, 1'b0, '{8'h05, 8'h08, 8'h00, 8'h00, 8'hAB, 8'hCD});
    endtask
    task t_drop();
        xact('{8'h05, 8'h03, 8'h00, 8'h03, 8'h00, 8'h01}, 1'b1, '{});
        xact('{8'h06, 8'h03, 8'h00, 8'h03, 8'h00, 8'h01}, 1'b0, '{});
        #1 host.rx_error = 1'b1;
        xact('{8'h05, 8'h03, 8'h00, 8'h03, 8'h00, 8'h01}, 1'b0, '{});
        #1 host.rx_error = 1'b0;
    endtask
    initial begin
        rst = 1'b1;
        addr_set_valid = 1'b0;
        addr_set_value = 8'h00;
        vol_add_valid = 1'b0;
        vol_add = 16'h0000;
        cfg_addr = 6'h03;
        foreach (meas[i]) meas[i] = 16'h0100 + 16'(i);
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        t_addr();
        t_read();
        t_write();
        t_drop();
        summarize();
    end
endmodule
